// File: rtl/i2csl_pkg.sv
// Shared constants for the I2C register-access slave and its bus master.
package i2csl_pkg;
   localparam logic [6:0] ADDR_BASE = 7'h48;
   localparam int AUTO_INC_BIT = 7;
   localparam int REG_SEL_MSB = 4;
   localparam int REG_COUNT = 32;
   localparam logic [4:0] SLEEP_CONFIGURATION_OFS = 5'h13;
   localparam logic [4:0] ACQUIRE_TIME_CONFIGURATION_OFS = 5'h14;
   localparam logic [4:0] POWER_UP_CONFIGURATION_OFS = 5'h15;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [7:0] POINTER_RESET = 8'h00;
   localparam int CLK_HZ = 100000000;
   localparam int STD_SCL_HZ = 100000;
   localparam int FAST_SCL_HZ = 400000;
   localparam int TIMEOUT_MS = 25;
   localparam int TIMEOUT_CYCLES = CLK_HZ / 1000 * TIMEOUT_MS;
   localparam int STD_HALF_CYCLES = CLK_HZ / (2 * STD_SCL_HZ) + 1;
   localparam int FAST_HALF_CYCLES = CLK_HZ / (2 * FAST_SCL_HZ) + 1;
   localparam logic [7:0] WB_CTRL_OFS = 8'h00;
   localparam logic [7:0] WB_DATA_OFS = 8'h04;
   localparam logic [7:0] WB_STATUS_OFS = 8'h08;
   localparam logic [7:0] WB_CFG_OFS = 8'h0c;
   localparam int CTRL_START_BIT = 0;
   localparam int CTRL_STOP_BIT = 1;
   localparam int CTRL_READ_BIT = 2;
   localparam int CTRL_WRITE_BIT = 3;
   localparam int CTRL_ACKOUT_BIT = 4;
   localparam int CFG_FAST_BIT = 0;
endpackage

// File: rtl/i2csl_if.sv
// Two-wire bus joining the slave and the master.
`timescale 1ns/100ps
`default_nettype none
interface i2csl_if;
   logic scl_o;
   logic scl_oe_n;
   logic sda_m_o;
   logic sda_m_oe_n;
   logic sda_s_o;
   logic sda_s_oe_n;
   logic scl;
   logic sda;
   // The wire is low when any end drives it; pull-ups make it high otherwise.
   assign scl = (scl_oe_n == 1'b0) ? scl_o : 1'b1;
   assign sda = ((sda_m_oe_n == 1'b0) && (sda_m_o == 1'b0))
      || ((sda_s_oe_n == 1'b0) && (sda_s_o == 1'b0)) ? 1'b0 : 1'b1;
   modport slave (input scl, input sda, output sda_s_o, output sda_s_oe_n);
   modport master (input scl, input sda, output scl_o, output scl_oe_n,
      output sda_m_o, output sda_m_oe_n);
endinterface
`default_nettype wire

// File: rtl/i2csl_slave.sv
// Register-access I2C slave with pointer and auto-increment.
//
// How it works
// - Samples SCL fast enough for 400 kHz.
// - SCL is input only; slave roles only.
// - First write byte loads the pointer, acked.
// - Later write bytes stored at pointer, acked.
// - Multi-byte content goes most significant first.
// - Read address sends selected register content.
// - Master acks each byte to continue.
// - NACK, START or STOP releases SDA.
// - Master sets pointer, then STOP or restart.
// - Pointer MSB is the auto-increment flag.
// - Pointer low five bits select register.
// - Flag set: advance after each write.
// - Flag set: advance after each read.
// - Flag clear: pointer holds after read.
// - Pointer persists across transfers.
// - Read begins with START then read address.
// - Address bit zero follows select pin continuously.
// - Idle mid-transfer beyond 25 ms returns to idle.
//
// Decided for this implementation: the Wishbone slave port.
`timescale 1ns/100ps
`default_nettype none
module i2csl_slave #(
   parameter int TIMEOUT_CYCLES = i2csl_pkg::TIMEOUT_CYCLES
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // Bus
   i2csl_if.slave bus,
   // Pins and register outputs
   input wire logic address_select_pin,
   output logic [7:0] sleep_configuration,
   output logic [7:0] acquire_time_configuration,
   output logic [7:0] power_up_configuration,
   output logic [7:0] pointer_value,
   output logic busy
);
   typedef enum logic [2:0] {
      I2CSL_IDLE = 3'b000,
      I2CSL_ADDR = 3'b001,
      I2CSL_ACK = 3'b010,
      I2CSL_RX = 3'b011,
      I2CSL_TX = 3'b100,
      I2CSL_TXACK = 3'b101,
      I2CSL_IGNORE = 3'b110
   } i2csl_state_t;

   logic [2:0] scl_sync_reg;
   logic [2:0] sda_sync_reg;
   logic [1:0] sel_sync_reg;
   i2csl_state_t state_reg;
   logic [3:0] bit_cnt_reg;
   logic [7:0] shift_reg;
   logic [7:0] pointer_reg;
   logic got_pointer_reg;
   logic read_mode_reg;
   logic ack_drive_reg;
   logic tx_drive_reg;
   logic [31:0] idle_cnt_reg;
   logic [7:0] regs_reg [i2csl_pkg::REG_COUNT];

   logic scl_rise;
   logic scl_fall;
   logic start_seen;
   logic stop_seen;
   logic scl_h;
   logic sda_h;
   logic [6:0] own_addr;
   logic [4:0] sel;
   logic timeout;

   // Three stages for SCL and SDA: the first two synchronise, the last gives the edge history; the select pin has two.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         scl_sync_reg <= 3'b111;
         sda_sync_reg <= 3'b111;
         sel_sync_reg <= 2'b00;
      end else begin
         scl_sync_reg <= {scl_sync_reg[1:0], bus.scl};
         sda_sync_reg <= {sda_sync_reg[1:0], bus.sda};
         sel_sync_reg <= {sel_sync_reg[0], address_select_pin};
      end
   end

   assign scl_h = scl_sync_reg[1];
   assign sda_h = sda_sync_reg[1];
   assign scl_rise = scl_sync_reg[1] && !scl_sync_reg[2];
   assign scl_fall = !scl_sync_reg[1] && scl_sync_reg[2];
   assign start_seen = scl_h && scl_sync_reg[2] && !sda_h && sda_sync_reg[2];
   assign stop_seen = scl_h && scl_sync_reg[2] && sda_h && !sda_sync_reg[2];
   assign own_addr = {i2csl_pkg::ADDR_BASE[6:1], sel_sync_reg[1]};
   assign sel = pointer_reg[i2csl_pkg::REG_SEL_MSB:0];
   assign timeout = (idle_cnt_reg >= 32'(TIMEOUT_CYCLES - 1));

   // Idle watchdog counts cycles without any bus line change mid-transfer.
   always_ff @(posedge clk_sys) begin
      if (sys_rst || state_reg == I2CSL_IDLE || scl_rise || scl_fall
            || (sda_h != sda_sync_reg[2])) begin
         idle_cnt_reg <= 32'h0;
      end else if (!timeout) begin
         idle_cnt_reg <= idle_cnt_reg + 32'h1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         state_reg <= I2CSL_IDLE;
         bit_cnt_reg <= 4'h0;
         shift_reg <= 8'h00;
         pointer_reg <= i2csl_pkg::POINTER_RESET;
         got_pointer_reg <= 1'b0;
         read_mode_reg <= 1'b0;
         ack_drive_reg <= 1'b0;
         tx_drive_reg <= 1'b0;
      end else if (start_seen) begin
         state_reg <= I2CSL_ADDR;
         bit_cnt_reg <= 4'h0;
         ack_drive_reg <= 1'b0;
         tx_drive_reg <= 1'b0;
         got_pointer_reg <= 1'b0;
      end else if (stop_seen || timeout) begin
         state_reg <= I2CSL_IDLE;
         ack_drive_reg <= 1'b0;
         tx_drive_reg <= 1'b0;
      end else begin
         case (state_reg)
            I2CSL_ADDR, I2CSL_RX: begin
               if (scl_rise) begin
                  shift_reg <= {shift_reg[6:0], sda_h};
                  bit_cnt_reg <= bit_cnt_reg + 4'h1;
               end else if (scl_fall && bit_cnt_reg == 4'h8) begin
                  bit_cnt_reg <= 4'h0;
                  if (state_reg == I2CSL_ADDR) begin
                     if (shift_reg[7:1] == own_addr) begin
                        read_mode_reg <= shift_reg[0];
                        ack_drive_reg <= 1'b1;
                        state_reg <= I2CSL_ACK;
                     end else begin
                        state_reg <= I2CSL_IGNORE;
                     end
                  end else begin
                     ack_drive_reg <= 1'b1;
                     state_reg <= I2CSL_ACK;
                     if (!got_pointer_reg) begin
                        pointer_reg <= shift_reg;
                        got_pointer_reg <= 1'b1;
                     end else if (pointer_reg[i2csl_pkg::AUTO_INC_BIT]) begin
                        pointer_reg[4:0] <= sel + 5'h1;
                     end
                  end
               end
            end
            I2CSL_ACK: begin
               if (scl_fall) begin
                  ack_drive_reg <= 1'b0;
                  if (read_mode_reg) begin
                     shift_reg <= regs_reg[sel];
                     tx_drive_reg <= 1'b1;
                     state_reg <= I2CSL_TX;
                  end else begin
                     state_reg <= I2CSL_RX;
                  end
               end
            end
            I2CSL_TX: begin
               if (scl_fall) begin
                  // Shifting out MSB first keeps the high bit ahead on the wire.
                  shift_reg <= {shift_reg[6:0], 1'b1};
                  bit_cnt_reg <= bit_cnt_reg + 4'h1;
                  if (bit_cnt_reg == 4'h7) begin
                     tx_drive_reg <= 1'b0;
                     bit_cnt_reg <= 4'h0;
                     state_reg <= I2CSL_TXACK;
                     if (pointer_reg[i2csl_pkg::AUTO_INC_BIT]) begin
                        pointer_reg[4:0] <= sel + 5'h1;
                     end
                  end
               end
            end
            I2CSL_TXACK: begin
               if (scl_rise) begin
                  if (sda_h) begin
                     state_reg <= I2CSL_IGNORE;
                  end else begin
                     bit_cnt_reg <= 4'h8;
                  end
               end else if (scl_fall && bit_cnt_reg == 4'h8) begin
                  bit_cnt_reg <= 4'h0;
                  shift_reg <= regs_reg[sel];
                  tx_drive_reg <= 1'b1;
                  state_reg <= I2CSL_TX;
               end
            end
            I2CSL_IGNORE, I2CSL_IDLE: begin
               ack_drive_reg <= 1'b0;
               tx_drive_reg <= 1'b0;
            end
            default: begin
               state_reg <= I2CSL_IDLE;
            end
         endcase
      end
   end

   // Register store: writes land after the pointer byte, in ack phase entry.
   genvar gi;
   generate
      for (gi = 0; gi < i2csl_pkg::REG_COUNT; gi = gi + 1) begin : g_regs
         always_ff @(posedge clk_sys) begin
            if (sys_rst) begin
               regs_reg[gi] <= i2csl_pkg::REG_RESET;
            end else if (!start_seen && !stop_seen && !timeout
                  && state_reg == I2CSL_RX && scl_fall && bit_cnt_reg == 4'h8
                  && got_pointer_reg && sel == 5'(gi)) begin
               regs_reg[gi] <= shift_reg;
            end
         end
      end
   endgenerate

   // SDA is only ever pulled low; releasing means the enable goes high.
   assign bus.sda_s_o = 1'b0;
   assign bus.sda_s_oe_n = !(ack_drive_reg || (tx_drive_reg && !shift_reg[7]));
   assign sleep_configuration = regs_reg[i2csl_pkg::SLEEP_CONFIGURATION_OFS];
   assign acquire_time_configuration = regs_reg[i2csl_pkg::ACQUIRE_TIME_CONFIGURATION_OFS];
   assign power_up_configuration = regs_reg[i2csl_pkg::POWER_UP_CONFIGURATION_OFS];
   assign pointer_value = pointer_reg;
   assign busy = (state_reg != I2CSL_IDLE);
endmodule // i2csl_slave
`default_nettype wire

// File: rtl/i2csl_master.sv
// Wishbone-controlled byte-level I2C master.
`timescale 1ns/100ps
`default_nettype none
module i2csl_master (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Bus
   i2csl_if.master bus
);
   typedef enum logic [2:0] {
      I2CSL_M_IDLE = 3'b000,
      I2CSL_M_START = 3'b001,
      I2CSL_M_BIT = 3'b010,
      I2CSL_M_STOP = 3'b011,
      I2CSL_M_DONE = 3'b100
   } i2csl_m_state_t;

   i2csl_m_state_t state_reg;
   logic [4:0] ctrl_reg;
   logic [7:0] tx_reg;
   logic [7:0] rx_reg;
   logic ack_in_reg;
   logic fast_reg;
   logic [9:0] div_reg;
   logic [1:0] phase_reg;
   logic [3:0] bit_reg;
   logic scl_reg;
   logic sda_reg;
   logic [1:0] sda_sync_reg;
   logic tick;
   logic wb_req;
   logic [9:0] half;

   assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   // Half period rounds up so the master never exceeds the selected rate.
   // The divider is wide enough for the standard-rate count without wrapping.
   assign half = fast_reg ? 10'(i2csl_pkg::FAST_HALF_CYCLES)
      : 10'(i2csl_pkg::STD_HALF_CYCLES);
   assign tick = (div_reg >= half - 10'h001);

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         sda_sync_reg <= 2'b11;
      end else begin
         sda_sync_reg <= {sda_sync_reg[0], bus.sda};
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
      end else begin
         wb_ack_o <= wb_req;
         if (wb_req && !wb_we_i) begin
            case (wb_adr_i)
               i2csl_pkg::WB_CTRL_OFS: wb_dat_o <= {27'h0, ctrl_reg};
               i2csl_pkg::WB_DATA_OFS: wb_dat_o <= {24'h0, rx_reg};
               i2csl_pkg::WB_STATUS_OFS: begin
                  wb_dat_o <= {30'h0, ack_in_reg, state_reg != I2CSL_M_IDLE};
               end
               i2csl_pkg::WB_CFG_OFS: wb_dat_o <= {31'h0, fast_reg};
               default: wb_dat_o <= 32'h0;
            endcase
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         fast_reg <= 1'b0;
         tx_reg <= 8'h00;
      end else if (wb_req && wb_we_i && wb_sel_i[0]) begin
         if (wb_adr_i == i2csl_pkg::WB_CFG_OFS) begin
            fast_reg <= wb_dat_i[i2csl_pkg::CFG_FAST_BIT];
         end
         if (wb_adr_i == i2csl_pkg::WB_DATA_OFS) begin
            tx_reg <= wb_dat_i[7:0];
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst || state_reg == I2CSL_M_IDLE || tick) begin
         div_reg <= 10'h000;
      end else begin
         div_reg <= div_reg + 10'h001;
      end
   end

   // Command sequence: optional START, optional byte, optional STOP; STOP is dropped after a START with no byte.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         state_reg <= I2CSL_M_IDLE;
         ctrl_reg <= 5'h00;
         rx_reg <= 8'h00;
         ack_in_reg <= 1'b0;
         phase_reg <= 2'h0;
         bit_reg <= 4'h0;
         scl_reg <= 1'b1;
         sda_reg <= 1'b1;
      end else begin
         case (state_reg)
            I2CSL_M_IDLE: begin
               phase_reg <= 2'h0;
               bit_reg <= 4'h0;
               if (wb_req && wb_we_i && wb_sel_i[0] && wb_adr_i == i2csl_pkg::WB_CTRL_OFS) begin
                  ctrl_reg <= wb_dat_i[4:0];
                  if (wb_dat_i[i2csl_pkg::CTRL_START_BIT]) begin
                     state_reg <= I2CSL_M_START;
                  end else if (wb_dat_i[i2csl_pkg::CTRL_READ_BIT]
                        || wb_dat_i[i2csl_pkg::CTRL_WRITE_BIT]) begin
                     state_reg <= I2CSL_M_BIT;
                  end else if (wb_dat_i[i2csl_pkg::CTRL_STOP_BIT]) begin
                     state_reg <= I2CSL_M_STOP;
                  end
               end
            end
            I2CSL_M_START: begin
               if (tick) begin
                  phase_reg <= phase_reg + 2'h1;
                  case (phase_reg)
                     2'h0: sda_reg <= 1'b1;
                     2'h1: scl_reg <= 1'b1;
                     2'h2: sda_reg <= 1'b0;
                     default: begin
                        scl_reg <= 1'b0;
                        phase_reg <= 2'h0;
                        state_reg <= (ctrl_reg[i2csl_pkg::CTRL_READ_BIT]
                           || ctrl_reg[i2csl_pkg::CTRL_WRITE_BIT]) ? I2CSL_M_BIT
                           : I2CSL_M_DONE;
                     end
                  endcase
               end
            end
            I2CSL_M_BIT: begin
               if (tick) begin
                  phase_reg <= phase_reg + 2'h1;
                  case (phase_reg)
                     2'h0: begin
                        if (bit_reg < 4'h8) begin
                           sda_reg <= ctrl_reg[i2csl_pkg::CTRL_WRITE_BIT]
                              ? tx_reg[3'(4'h7 - bit_reg)] : 1'b1;
                        end else begin
                           sda_reg <= ctrl_reg[i2csl_pkg::CTRL_WRITE_BIT] ? 1'b1
                              : !ctrl_reg[i2csl_pkg::CTRL_ACKOUT_BIT];
                        end
                     end
                     2'h1: scl_reg <= 1'b1;
                     2'h2: begin
                        if (bit_reg < 4'h8) begin
                           rx_reg <= {rx_reg[6:0], sda_sync_reg[1]};
                        end else begin
                           ack_in_reg <= !sda_sync_reg[1];
                        end
                     end
                     default: begin
                        scl_reg <= 1'b0;
                        phase_reg <= 2'h0;
                        bit_reg <= bit_reg + 4'h1;
                        if (bit_reg == 4'h8) begin
                           state_reg <= ctrl_reg[i2csl_pkg::CTRL_STOP_BIT] ? I2CSL_M_STOP
                              : I2CSL_M_DONE;
                        end
                     end
                  endcase
               end
            end
            I2CSL_M_STOP: begin
               if (tick) begin
                  phase_reg <= phase_reg + 2'h1;
                  case (phase_reg)
                     2'h0: sda_reg <= 1'b0;
                     2'h1: scl_reg <= 1'b1;
                     2'h2: sda_reg <= 1'b1;
                     default: state_reg <= I2CSL_M_DONE;
                  endcase
               end
            end
            I2CSL_M_DONE: begin
               ctrl_reg <= 5'h00;
               state_reg <= I2CSL_M_IDLE;
            end
            default: state_reg <= I2CSL_M_IDLE;
         endcase
      end
   end

   // Open-drain: a high level is produced by releasing the line.
   assign bus.scl_o = 1'b0;
   assign bus.scl_oe_n = scl_reg;
   assign bus.sda_m_o = 1'b0;
   assign bus.sda_m_oe_n = sda_reg;
endmodule // i2csl_master
`default_nettype wire

// File: tb/i2csl_monitor.sv
// Protocol checker for the two-wire bus between the slave and the master.
`timescale 1ns/100ps
`default_nettype none
module i2csl_monitor #(
   parameter int TIMEOUT_CYCLES = 2000
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // Bus lines and slave drivers
   input wire logic scl,
   input wire logic sda,
   input wire logic sda_s_o,
   input wire logic sda_s_oe_n,
   // Pins
   input wire logic address_select_pin
);
   logic scl_q, sda_q, rw_reg, foreign_reg, nacked_reg, start_seen, ack_rise;
   logic [3:0] bit_cnt;
   logic [1:0] byte_idx;
   logic [7:0] shift_reg;
   int idle_cnt;
   assign start_seen = scl && scl_q && sda_q && !sda;
   assign ack_rise = scl && !scl_q && (bit_cnt == 4'h8);
   always_ff @(posedge clk_sys) begin
      scl_q <= sys_rst ? 1'b1 : scl;
      sda_q <= sys_rst ? 1'b1 : sda;
   end
   // Bit and byte position inside the frame, restarted by every START.
   always_ff @(posedge clk_sys) begin
      if (sys_rst || start_seen) begin
         bit_cnt <= 4'h0;
         byte_idx <= 2'h0;
      end else if (scl && !scl_q) begin
         if (bit_cnt == 4'h8) begin
            bit_cnt <= 4'h0;
            byte_idx <= (byte_idx == 2'h3) ? byte_idx : byte_idx + 2'h1;
         end else begin
            bit_cnt <= bit_cnt + 4'h1;
            shift_reg <= {shift_reg[6:0], sda};
         end
      end
   end
   always_ff @(posedge clk_sys) begin
      if (sys_rst || start_seen) begin
         rw_reg <= 1'b0;
         foreign_reg <= 1'b0;
         nacked_reg <= 1'b0;
      end else if (ack_rise && byte_idx == 2'h0) begin
         rw_reg <= shift_reg[0];
         foreign_reg <= shift_reg[7:1] != {6'b100100, address_select_pin};
      end else if (ack_rise && rw_reg && sda) begin
         nacked_reg <= 1'b1;
      end
   end
   // Counts cycles with both lines frozen; saturates well below overflow.
   always_ff @(posedge clk_sys) begin
      if (sys_rst || scl != scl_q || sda != sda_q) begin
         idle_cnt <= 0;
      end else if (idle_cnt < 32'h0fffffff) begin
         idle_cnt <= idle_cnt + 1;
      end
   end
   default clocking mon_cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   a_open_drain_low: assert property (!sda_s_oe_n |-> sda_s_o == 1'b0)
      else $error("slave drives SDA high");
   a_pull_on_low: assert property ($fell(sda_s_oe_n) |-> !scl)
      else $error("slave starts pulling SDA while SCL is high");
   a_hold_while_high: assert property (
      scl && scl_q && !$past(sda_s_oe_n) |-> !sda_s_oe_n)
      else $error("slave releases SDA while SCL is high");
   a_addr_match: assert property (
      ack_rise && byte_idx == 2'h0
      |-> (!sda_s_oe_n) == (shift_reg[7:1] == {6'b100100, address_select_pin}))
      else $error("address acknowledge does not follow the select pin");
   a_write_ack: assert property (
      ack_rise && byte_idx != 2'h0 && !rw_reg && !foreign_reg |-> !sda_s_oe_n)
      else $error("write byte not acknowledged");
   a_foreign_quiet: assert property (foreign_reg |-> sda_s_oe_n)
      else $error("slave drives SDA after a foreign address");
   a_nack_release: assert property (nacked_reg |-> sda_s_oe_n)
      else $error("slave keeps sending after a not-acknowledge");
   a_timeout_release: assert property (idle_cnt > TIMEOUT_CYCLES + 16 |-> sda_s_oe_n)
      else $error("slave holds SDA past the idle timeout");
   c_read_ack: cover property (ack_rise && rw_reg && byte_idx == 2'h1);
   c_foreign: cover property ($rose(foreign_reg));
   c_idle_long: cover property (idle_cnt == TIMEOUT_CYCLES + 20);
endmodule // i2csl_monitor
`default_nettype wire

// File: tb/tb_i2c_slave_register_access.sv
// Self-checking bench: master and slave joined on one bus, driven over Wishbone.
`timescale 1ns/100ps
`default_nettype none
module tb_i2c_slave_register_access;
   localparam int TO = 2000;
   localparam int LIMIT = 99000;
   localparam logic [7:0] C_S = 8'h01;
   localparam logic [7:0] C_P = 8'h02;
   localparam logic [7:0] C_R = 8'h04;
   localparam logic [7:0] C_W = 8'h08;
   localparam logic [7:0] C_A = 8'h10;
   logic clk_sys, sys_rst, cyc, stb, we, ack, pin, busy, ackd;
   logic [3:0] sel;
   logic [7:0] adr, sleep_q, acq_q, pwr_q, ptr_q, rx, b, mptr;
   logic [31:0] wdat, rdat, rd, st;
   logic [7:0] mreg [0:31];
   int fail_count, check_count, cycles, i;
   int seed = 32'hed5281b2;
   i2csl_if bus_if();
   i2csl_slave #(.TIMEOUT_CYCLES(TO)) i2csl_slave_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
      .bus(bus_if.slave), .address_select_pin(pin), .sleep_configuration(sleep_q),
      .acquire_time_configuration(acq_q), .power_up_configuration(pwr_q),
      .pointer_value(ptr_q), .busy(busy));
   i2csl_master i2csl_master_inst (.clk_sys(clk_sys), .sys_rst(sys_rst), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .bus(bus_if.master));
   i2csl_monitor #(.TIMEOUT_CYCLES(TO)) i2csl_monitor_inst (.clk_sys(clk_sys),
      .sys_rst(sys_rst), .scl(bus_if.scl), .sda(bus_if.sda), .sda_s_o(bus_if.sda_s_o),
      .sda_s_oe_n(bus_if.sda_s_oe_n), .address_select_pin(pin));
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   task automatic conclude();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == LIMIT) begin
         fail_count++;
         conclude();
      end
   end
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      check_count++;
      if (g !== e) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   // Entered just after a rising edge; request held until ack is sampled high.
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= 4'h1;
      do @(posedge clk_sys); while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      @(posedge clk_sys);
   endtask
   // One master command; STATUS is polled until the bus operation is over.
   task automatic cmd(input logic [7:0] c, input logic [7:0] tx);
      if (c[3]) wb(1'b1, 8'h04, {24'h0, tx}, rd);
      wb(1'b1, 8'h00, {24'h0, c}, rd);
      do wb(1'b0, 8'h08, 32'h0, st); while (st[0] === 1'b1);
      wb(1'b0, 8'h04, 32'h0, rd);
      rx = rd[7:0];
      ackd = st[1];
   endtask
   task automatic ackchk(input string n, input logic e);
      chk(n, {7'h0, e}, {7'h0, ackd});
   endtask
   task automatic mwr(input logic [7:0] d);
      mreg[mptr[4:0]] = d;
      if (mptr[7]) mptr[4:0] = mptr[4:0] + 5'h1;
   endtask
   task automatic rdchk(input logic [7:0] c);
      cmd(c, 8'h00);
      chk("read byte", mreg[mptr[4:0]], rx);
      if (mptr[7]) mptr[4:0] = mptr[4:0] + 5'h1;
   endtask
   task automatic setptr(input logic [7:0] a, input logic [7:0] p, input logic [7:0] c);
      cmd(C_S | C_W, a);
      cmd(c, p);
      ackchk("pointer ack", 1'b1);
      mptr = p;
      chk("pointer loaded", p, ptr_q);
   endtask
   initial begin
      {cyc, stb, we, pin, sys_rst} = 5'h01;
      adr = 8'h00;
      wdat = 32'h0;
      sel = 4'h0;
      for (i = 0; i < 32; i++) mreg[i] = 8'h00;
      repeat (20) @(posedge clk_sys);
      sys_rst <= 1'b0;
      @(posedge clk_sys);
      chk("reset pointer", 8'h00, ptr_q);
      chk("reset register", 8'h00, sleep_q);
      chk("reset busy", 8'h00, {7'h0, busy});
      wb(1'b1, 8'h0c, 32'h1, rd);
      setptr(8'h90, 8'h93, C_W);
      for (i = 0; i < 2; i++) begin
         b = 8'($random(seed));
         cmd((i == 1) ? (C_W | C_P) : C_W, b);
         ackchk("data ack", 1'b1);
         mwr(b);
      end
      chk("sleep_configuration", mreg[19], sleep_q);
      chk("acquire_time_configuration", mreg[20], acq_q);
      chk("power_up_configuration", mreg[21], pwr_q);
      chk("pointer", mptr, ptr_q);
      // The read address follows the pointer byte by a repeated START.
      setptr(8'h90, 8'h93, C_W);
      cmd(C_S | C_W, 8'h91);
      ackchk("read address ack", 1'b1);
      rdchk(C_R | C_A);
      rdchk(C_R);
      chk("pointer", mptr, ptr_q);
      pin <= 1'b1;
      repeat (8) @(posedge clk_sys);
      cmd(C_S | C_W | C_P, 8'h90);
      ackchk("foreign address ack", 1'b0);
      // Standard rate costs four times the cycles, so only one address byte uses it.
      wb(1'b1, 8'h0c, 32'h0, rd);
      cmd(C_S | C_W, 8'h92);
      ackchk("standard rate ack", 1'b1);
      wb(1'b1, 8'h0c, 32'h1, rd);
      cmd(C_W, 8'h14);
      ackchk("pointer ack", 1'b1);
      mptr = 8'h14;
      chk("pointer", mptr, ptr_q);
      b = 8'($random(seed));
      cmd(C_W, b);
      ackchk("data ack", 1'b1);
      mwr(b);
      // The frame is left open so that only the idle watchdog can end it.
      chk("busy mid transfer", 8'h01, {7'h0, busy});
      repeat (TO + 100) @(posedge clk_sys);
      chk("busy after idle", 8'h00, {7'h0, busy});
      chk("acquire_time_configuration", mreg[20], acq_q);
      chk("power_up_configuration", mreg[21], pwr_q);
      cmd(C_S | C_W, 8'h93);
      ackchk("ack after timeout", 1'b1);
      rdchk(C_R | C_A);
      rdchk(C_R | C_P);
      chk("pointer", mptr, ptr_q);
      conclude();
   end
endmodule // tb_i2c_slave_register_access
`default_nettype wire
